// >>> logic/bcs_pkg.sv
// shared types and constants for the boot and configuration sequencer
package bcs_pkg;

  localparam int unsigned IDX_W = 3;
  localparam logic [IDX_W-1:0] FACTORY_SLOT = 3'h0;
  localparam logic [IDX_W-1:0] ATTEMPT_RST  = 3'h0;
  localparam logic RST_PROC_RST_N = 1'b0;
  localparam logic RST_PIN_OE_N   = 1'b0;

  typedef enum logic [2:0] {
    ST_STRAP,
    ST_WAIT_REQ,
    ST_STEP,
    ST_RETRY,
    ST_RUN,
    ST_FAIL
  } bcs_state_e;

  typedef enum logic [2:0] {
    STEP_AUTH_FW,
    STEP_VERIFY_FW,
    STEP_VERIFY_BS,
    STEP_CFG_MEM_IO,
    STEP_CFG_FABRIC,
    STEP_LOAD_LOADER
  } bcs_step_e;

  typedef enum logic [1:0] {
    SRC_STREAM,
    SRC_JTAG,
    SRC_FLASH
  } bcs_src_e;

  typedef struct packed {
    logic     proc_first;
    logic     eng_sample;
    logic     dual_flash;
    logic     upd_en;
    logic     direct_factory;
    bcs_src_e src;
  } bcs_straps_s;

  typedef struct packed {
    bcs_state_e  state;
    bcs_step_e   code;
    logic        step_start;
    logic        proc_rst_n;
    logic        fabric_done;
    logic        mem_io_done;
    logic        pin_val;
    logic        pin_oe_n;
    logic        boot_fail;
    logic        sec_en;
    logic        sec_refused;
    logic        key_wipe;
    logic        key_perm;
    bcs_straps_s straps;
  } bcs_core_s;

  typedef struct packed {
    logic [IDX_W-1:0] attempt;
    logic [IDX_W-1:0] image;
    logic             factory;
    logic             exhausted;
  } bcs_sel_s;

  localparam bcs_straps_s STRAPS_RST = '{src: SRC_FLASH, default: 1'b0};

  localparam bcs_core_s CORE_RST = '{
    state:      ST_STRAP,
    code:       STEP_AUTH_FW,
    proc_rst_n: RST_PROC_RST_N,
    pin_oe_n:   RST_PIN_OE_N,
    straps:     STRAPS_RST,
    default:    1'b0
  };

  localparam bcs_sel_s SEL_RST = '{
    attempt:   ATTEMPT_RST,
    image:     FACTORY_SLOT,
    factory:   1'b1,
    exhausted: 1'b0
  };

endpackage

// >>> logic/bcs_image_sel.sv
// image selector: production images in user order, then factory image
`timescale 1ns/1ns
module bcs_image_sel
#(
  parameter int unsigned N_PROD = 4
)
(
  // clock and reset
  input  wire logic                                 clk_in,
  input  wire logic                                 rst_b_in,
  // control
  input  wire logic                                 restart_in,
  input  wire logic                                 use_update_in,
  input  wire logic                                 direct_factory_in,
  input  wire logic                                 fail_in,
  input  wire logic [N_PROD-1:0][bcs_pkg::IDX_W-1:0] order_in,
  // selection
  output logic      [bcs_pkg::IDX_W-1:0]            image_out,
  output logic                                      factory_out,
  output logic                                      exhausted_out
);
  import bcs_pkg::*;

  localparam logic [IDX_W-1:0] LAST = IDX_W'(N_PROD - 1);

  bcs_sel_s s_ff;
  bcs_sel_s nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    if (restart_in)
    begin
      nxt_s.attempt   = ATTEMPT_RST;
      nxt_s.exhausted = 1'b0;
      nxt_s.factory   = direct_factory_in | ~use_update_in;
    end
    else if (fail_in)
    begin
      if (s_ff.factory)
        nxt_s.exhausted = 1'b1;
      else if (s_ff.attempt == LAST)
        nxt_s.factory = 1'b1;
      else
        nxt_s.attempt = s_ff.attempt + 1'b1;
    end
    nxt_s.image = nxt_s.factory ? FACTORY_SLOT : order_in[nxt_s.attempt];
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      s_ff <= SEL_RST;
    else
      s_ff <= nxt_s;
  end

  assign image_out     = s_ff.image;
  assign factory_out   = s_ff.factory;
  assign exhausted_out = s_ff.exhausted;

  AST_DIRECT_FACTORY:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      restart_in && direct_factory_in |=> factory_out && image_out == 3'h0)
    else $error("direct to factory did not select factory image");

  AST_PROD_ORDER:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !restart_in && fail_in && !s_ff.factory && s_ff.attempt != LAST
      |=> !factory_out && s_ff.attempt == $past(s_ff.attempt) + 1'b1)
    else $error("production image order not followed");

endmodule

// >>> logic/boot_config_sequencer.sv
// boot and configuration sequencer top: boot orders, resets, security gates
//
// Functional notes
// - fabric-first: configure whole fabric and I/O, then load loader, release.
// - fabric-first: any configuration error keeps the processor in reset.
// - processor-first: configure memory-port I/O only, load loader, release.
// - config request held postpones configuration; assertion restarts full.
// - config request assertion also cold resets the processor.
// - two-way cold-reset pin; external low resets processor only.
// - remote update: production images in user order, then factory image.
// - security features refused unless owner authentication enabled.
// - firmware always authenticated; firmware and bitstream always checked.
// - no processor boot code; loader comes from the bitstream.
// - image from streaming, JTAG or flash; source supplies whole image.
// - engineering samples boot only processor-first with dual flash.
// - decryption key in battery RAM (wipeable) or fuses (permanent).
// - root key hash and key cancellation enforced from fuses.
// - direct-to-factory at power-on skips all production images.
// - cold-reset pin output resets other board devices with processor.
`timescale 1ns/1ns
module boot_config_sequencer
#(
  parameter int unsigned N_PROD = 4
)
(
  // clock and reset
  input  wire logic                                 REF_CLK_IN,
  input  wire logic                                 RST_B_IN,
  // configuration request and straps
  input  wire logic                                 CONFIG_REQUEST_N_IN,
  input  wire bcs_pkg::bcs_straps_s                 STRAPS_IN,
  input  wire logic [N_PROD-1:0][bcs_pkg::IDX_W-1:0] PROD_ORDER_IN,
  // processor cold-reset pin
  input  wire logic                                 PROC_COLD_RESET_N_IN,
  output logic                                      PROC_COLD_RESET_N_OUT,
  output logic                                      PROC_COLD_RESET_OE_N_OUT,
  // step engine
  output logic                                      STEP_START_OUT,
  output bcs_pkg::bcs_step_e                        STEP_CODE_OUT,
  output logic      [bcs_pkg::IDX_W-1:0]            IMAGE_SEL_OUT,
  output logic                                      FACTORY_SEL_OUT,
  output bcs_pkg::bcs_src_e                         IMAGE_SOURCE_OUT,
  input  wire logic                                 STEP_DONE_IN,
  input  wire logic                                 STEP_ERR_IN,
  // fuses and security
  input  wire logic                                 ROOT_HASH_OK_IN,
  input  wire logic                                 KEY_CANCELLED_IN,
  input  wire logic                                 OWNER_AUTH_IN,
  input  wire logic                                 SEC_FEATURE_REQ_IN,
  input  wire logic                                 KEY_IN_FUSE_IN,
  input  wire logic                                 KEY_WIPE_REQ_IN,
  output logic                                      SEC_ENABLE_OUT,
  output logic                                      SEC_REFUSED_OUT,
  output logic                                      KEY_WIPE_OUT,
  output logic                                      KEY_PERMANENT_OUT,
  // processor and fabric status
  output logic                                      PROC_RESET_N_OUT,
  output logic                                      FABRIC_CFG_DONE_OUT,
  output logic                                      MEM_IO_CFG_DONE_OUT,
  output logic                                      BOOT_FAIL_OUT
);
  import bcs_pkg::*;

  bcs_core_s s_ff;
  bcs_core_s nxt_s;
  logic      step_ok;
  logic      err_now;
  logic      sel_restart;
  logic      sel_exhausted;

  function automatic logic es_bad(input bcs_straps_s st);
    es_bad = st.eng_sample & ~(st.proc_first & st.dual_flash);
  endfunction

  function automatic bcs_step_e next_step(input bcs_step_e c,
                                          input logic proc_first);
    case (c)
      STEP_AUTH_FW:     next_step = STEP_VERIFY_FW;
      STEP_VERIFY_FW:   next_step = STEP_VERIFY_BS;
      STEP_VERIFY_BS:   next_step = proc_first ? STEP_CFG_MEM_IO
                                               : STEP_CFG_FABRIC;
      STEP_CFG_FABRIC:  next_step = STEP_CFG_MEM_IO;
      default:          next_step = STEP_LOAD_LOADER;
    endcase
  endfunction

  assign step_ok = STEP_DONE_IN & ~STEP_ERR_IN &
                   ((s_ff.code != STEP_AUTH_FW) |
                    (ROOT_HASH_OK_IN & ~KEY_CANCELLED_IN));
  assign err_now = (s_ff.state == ST_STEP) & ~s_ff.step_start & ~step_ok &
                   (STEP_DONE_IN | STEP_ERR_IN) & CONFIG_REQUEST_N_IN;
  assign sel_restart = (s_ff.state == ST_WAIT_REQ);

  // image selector for any source; remote update only from flash
  // only flash holds several images; other sources bring one whole image
  bcs_image_sel #(.N_PROD(N_PROD)) u_sel
  (
    .clk_in            (REF_CLK_IN),
    .rst_b_in          (RST_B_IN),
    .restart_in        (sel_restart),
    .use_update_in     (s_ff.straps.upd_en &
                        (s_ff.straps.src == SRC_FLASH)),
    .direct_factory_in (s_ff.straps.direct_factory),
    .fail_in           (err_now),
    .order_in          (PROD_ORDER_IN),
    .image_out         (IMAGE_SEL_OUT),
    .factory_out       (FACTORY_SEL_OUT),
    .exhausted_out     (sel_exhausted)
  );

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.step_start = 1'b0;
    nxt_s.pin_val    = 1'b0;
    nxt_s.sec_en      = SEC_FEATURE_REQ_IN & OWNER_AUTH_IN;
    nxt_s.sec_refused = SEC_FEATURE_REQ_IN & ~OWNER_AUTH_IN;
    nxt_s.key_perm = KEY_IN_FUSE_IN;
    nxt_s.key_wipe = KEY_WIPE_REQ_IN & ~KEY_IN_FUSE_IN;
    case (s_ff.state)
      ST_STRAP:
      begin
        nxt_s.straps = STRAPS_IN;
        nxt_s.state  = ST_WAIT_REQ;
      end
      ST_WAIT_REQ:
      begin
        if (CONFIG_REQUEST_N_IN)
        begin
          if (es_bad(s_ff.straps))
          begin
            nxt_s.state     = ST_FAIL;
            nxt_s.boot_fail = 1'b1;
          end
          else
          begin
            nxt_s.state      = ST_STEP;
            nxt_s.code       = STEP_AUTH_FW;
            nxt_s.step_start = 1'b1;
          end
        end
      end
      ST_STEP:
      begin
        if (!s_ff.step_start && step_ok)
        begin
          if (s_ff.code == STEP_LOAD_LOADER)
          begin
            nxt_s.state      = ST_RUN;
            nxt_s.proc_rst_n = 1'b1;
            nxt_s.pin_oe_n   = 1'b1;
          end
          else
          begin
            if (s_ff.code == STEP_CFG_FABRIC)
              nxt_s.fabric_done = 1'b1;
            if (s_ff.code == STEP_CFG_MEM_IO)
              nxt_s.mem_io_done = 1'b1;
            nxt_s.code       = next_step(s_ff.code, s_ff.straps.proc_first);
            nxt_s.step_start = 1'b1;
          end
        end
        else if (err_now)
        begin
          nxt_s.state        = ST_RETRY;
          nxt_s.fabric_done  = 1'b0;
          nxt_s.mem_io_done  = 1'b0;
        end
      end
      ST_RETRY:
      begin
        if (sel_exhausted)
        begin
          nxt_s.state     = ST_FAIL;
          nxt_s.boot_fail = 1'b1;
        end
        else
        begin
          nxt_s.state      = ST_STEP;
          nxt_s.code       = STEP_AUTH_FW;
          nxt_s.step_start = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (!PROC_COLD_RESET_N_IN)
        begin
          nxt_s.state      = ST_STEP;
          nxt_s.code       = STEP_LOAD_LOADER;
          nxt_s.step_start = 1'b1;
          nxt_s.proc_rst_n = 1'b0;
          nxt_s.pin_oe_n   = 1'b0;
        end
      end
      ST_FAIL:
        nxt_s.state = ST_FAIL;
      default:
        nxt_s.state = ST_STRAP;
    endcase
    if (!CONFIG_REQUEST_N_IN && s_ff.state != ST_STRAP)
    begin
      nxt_s.state        = ST_WAIT_REQ;
      nxt_s.step_start   = 1'b0;
      nxt_s.proc_rst_n   = 1'b0;
      nxt_s.pin_oe_n     = 1'b0;
      nxt_s.fabric_done  = 1'b0;
      nxt_s.mem_io_done  = 1'b0;
      nxt_s.boot_fail    = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      s_ff <= CORE_RST;
    else
      s_ff <= nxt_s;
  end

  assign PROC_COLD_RESET_N_OUT      = s_ff.pin_val;
  assign PROC_COLD_RESET_OE_N_OUT   = s_ff.pin_oe_n;
  assign STEP_START_OUT             = s_ff.step_start;
  assign STEP_CODE_OUT              = s_ff.code;
  assign IMAGE_SOURCE_OUT           = s_ff.straps.src;
  assign SEC_ENABLE_OUT             = s_ff.sec_en;
  assign SEC_REFUSED_OUT            = s_ff.sec_refused;
  assign KEY_WIPE_OUT               = s_ff.key_wipe;
  assign KEY_PERMANENT_OUT          = s_ff.key_perm;
  assign PROC_RESET_N_OUT           = s_ff.proc_rst_n;
  assign FABRIC_CFG_DONE_OUT        = s_ff.fabric_done;
  assign MEM_IO_CFG_DONE_OUT        = s_ff.mem_io_done;
  assign BOOT_FAIL_OUT              = s_ff.boot_fail;

  AST_FABRIC_FIRST:
    assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      $rose(PROC_RESET_N_OUT) && !s_ff.straps.proc_first
      |-> FABRIC_CFG_DONE_OUT && MEM_IO_CFG_DONE_OUT)
    else $error("processor released before fabric configured");

  AST_FAIL_HOLDS:
    assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      BOOT_FAIL_OUT |-> !PROC_RESET_N_OUT && !FABRIC_CFG_DONE_OUT)
    else $error("processor released after configuration error");

  AST_PROC_FIRST:
    assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      $rose(PROC_RESET_N_OUT) && s_ff.straps.proc_first
      |-> MEM_IO_CFG_DONE_OUT && !FABRIC_CFG_DONE_OUT)
    else $error("processor-first released with wrong configuration");

  AST_CFG_REQ:
    assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      !CONFIG_REQUEST_N_IN && s_ff.state != ST_STRAP
      |=> !PROC_RESET_N_OUT && !FABRIC_CFG_DONE_OUT && !STEP_START_OUT
          && !PROC_COLD_RESET_OE_N_OUT)
    else $error("config request did not reset processor and fabric");

  AST_COLD_PIN:
    assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      s_ff.state == ST_RUN && !PROC_COLD_RESET_N_IN && CONFIG_REQUEST_N_IN
      |=> !PROC_RESET_N_OUT && $stable(FABRIC_CFG_DONE_OUT)
          && STEP_START_OUT && STEP_CODE_OUT == STEP_LOAD_LOADER)
    else $error("cold-reset pin did not reset processor alone");

  AST_SEC_GATE:
    assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      SEC_ENABLE_OUT |-> $past(OWNER_AUTH_IN) && !SEC_REFUSED_OUT)
    else $error("security enabled without owner authentication");

  AST_AUTH_FUSE:
    assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      s_ff.state == ST_STEP && s_ff.code == STEP_AUTH_FW && !STEP_START_OUT
      && STEP_DONE_IN && (KEY_CANCELLED_IN || !ROOT_HASH_OK_IN)
      && CONFIG_REQUEST_N_IN |=> s_ff.state == ST_RETRY)
    else $error("cancelled key or bad hash accepted");

  AST_SAMPLE:
    assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      s_ff.state == ST_WAIT_REQ && CONFIG_REQUEST_N_IN
      && es_bad(s_ff.straps) |=> BOOT_FAIL_OUT ##1 !PROC_RESET_N_OUT)
    else $error("engineering sample booted in unsupported order");

  AST_KEY_WIPE:
    assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      KEY_WIPE_OUT |-> !$past(KEY_IN_FUSE_IN) && !KEY_PERMANENT_OUT)
    else $error("fuse key wiped");

  AST_RELEASE_SRC:
    assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      $rose(PROC_RESET_N_OUT) |-> $past(s_ff.state) == ST_STEP
      && $past(s_ff.code) == STEP_LOAD_LOADER)
    else $error("processor released outside loader completion");

endmodule

// >>> test/bcs_src_model.sv
// image source model: answers each sequencer step with done or error
`timescale 1ns/1ns
module bcs_src_model
(
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  // step handshake
  input  wire logic               abort_in,
  input  wire logic               start_in,
  input  wire bcs_pkg::bcs_step_e code_in,
  input  wire logic [2:0]         image_in,
  output logic                    done_out,
  output logic                    err_out,
  // fault plan set by the bench
  input  wire logic [7:0]         fail_mask_in,
  input  wire bcs_pkg::bcs_step_e fail_code_in,
  input  wire logic [3:0]         delay_in
);
  import bcs_pkg::*;
  logic       busy_ff;
  logic       bad_ff;
  logic [3:0] cnt_ff;
  always_ff @(negedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      busy_ff  <= 1'b0;
      bad_ff   <= 1'b0;
      cnt_ff   <= 4'h0;
      done_out <= 1'b0;
      err_out  <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      err_out  <= 1'b0;
      // a held config request stops the transfer, no stray answer later
      if (abort_in)
        busy_ff <= 1'b0;
      else if (start_in)
      begin
        busy_ff <= 1'b1;
        cnt_ff  <= delay_in;
        bad_ff  <= fail_mask_in[image_in] && (code_in == fail_code_in);
      end
      else if (busy_ff)
      begin
        if (cnt_ff == 4'h0)
        begin
          busy_ff  <= 1'b0;
          done_out <= !bad_ff;
          err_out  <= bad_ff;
        end
        else
          cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule

// >>> test/tb.sv
// self-checking bench for the boot and configuration sequencer
`timescale 1ns/1ns
module tb;
  import bcs_pkg::*;
  localparam int unsigned NP = 4;
  logic                     clk, rst_b, cfg_n, ext_low, done, err;
  logic                     hash_ok, key_cnc, owner, sreq, kfuse, kwipe;
  logic                     pin_out, pin_oe_n, start, fsel, sen, sref;
  logic                     kwo, kperm, prst_n, fab, mio, bfail;
  logic [2:0]               img;
  logic [3:0]               dly;
  logic [7:0]               fmask;
  logic [NP-1:0][IDX_W-1:0] order;
  bcs_straps_s              straps;
  bcs_step_e                code, fcode;
  bcs_src_e                 src;
  int                       miscompares, n_compared, cycles;
  logic [2:0]               codes_q[$];
  logic [2:0]               imgs_q[$];
  logic [2:0]               ff_q[$] = '{STEP_AUTH_FW, STEP_VERIFY_FW,
    STEP_VERIFY_BS, STEP_CFG_FABRIC, STEP_CFG_MEM_IO, STEP_LOAD_LOADER};
  logic [2:0]               pf_q[$] = '{STEP_AUTH_FW, STEP_VERIFY_FW,
    STEP_VERIFY_BS, STEP_CFG_MEM_IO, STEP_LOAD_LOADER};
  // pin has a board pull-up; either party may pull it low
  wire pin = ((!pin_oe_n && !pin_out) || ext_low) ? 1'b0 : 1'b1;

  boot_config_sequencer #(.N_PROD(NP)) i_dut (
    .REF_CLK_IN(clk), .RST_B_IN(rst_b), .CONFIG_REQUEST_N_IN(cfg_n),
    .STRAPS_IN(straps), .PROD_ORDER_IN(order),
    .PROC_COLD_RESET_N_IN(pin), .PROC_COLD_RESET_N_OUT(pin_out),
    .PROC_COLD_RESET_OE_N_OUT(pin_oe_n), .STEP_START_OUT(start),
    .STEP_CODE_OUT(code), .IMAGE_SEL_OUT(img), .FACTORY_SEL_OUT(fsel),
    .IMAGE_SOURCE_OUT(src), .STEP_DONE_IN(done), .STEP_ERR_IN(err),
    .ROOT_HASH_OK_IN(hash_ok), .KEY_CANCELLED_IN(key_cnc),
    .OWNER_AUTH_IN(owner), .SEC_FEATURE_REQ_IN(sreq),
    .KEY_IN_FUSE_IN(kfuse), .KEY_WIPE_REQ_IN(kwipe),
    .SEC_ENABLE_OUT(sen), .SEC_REFUSED_OUT(sref), .KEY_WIPE_OUT(kwo),
    .KEY_PERMANENT_OUT(kperm), .PROC_RESET_N_OUT(prst_n),
    .FABRIC_CFG_DONE_OUT(fab), .MEM_IO_CFG_DONE_OUT(mio),
    .BOOT_FAIL_OUT(bfail));

  bcs_src_model i_src (
    .clk_in(clk), .rst_b_in(rst_b), .abort_in(!cfg_n), .start_in(start),
    .code_in(code), .image_in(img), .done_out(done), .err_out(err),
    .fail_mask_in(fmask), .fail_code_in(fcode), .delay_in(dly));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // log every step start, and the image at each authentication
  always @(negedge clk)
  begin
    if (start === 1'b1)
    begin
      codes_q.push_back(code);
      if (code == STEP_AUTH_FW)
        imgs_q.push_back(img);
    end
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_q(input string nm, input logic [2:0] e[$], g[$]);
    chk({nm, " count"}, 8'(e.size()), 8'(g.size()));
    foreach (e[i])
      if (i < g.size())
        chk(nm, e[i], g[i]);
  endtask

  function automatic bcs_straps_s mk(input logic pf, es, df, upd, dfac,
                                     input bcs_src_e sr);
    mk = '{pf, es, df, upd, dfac, sr};
  endfunction

  // straps must be steady at the first edge after release
  task automatic reset_dut(input bcs_straps_s s);
    rst_b = 1'b0;
    straps = s;
    repeat (12) @(negedge clk);
    codes_q.delete();
    imgs_q.delete();
    rst_b = 1'b1;
  endtask

  task automatic wait_end();
    int n;
    n = 0;
    while (prst_n !== 1'b1 && bfail !== 1'b1 && n < 800)
    begin
      @(negedge clk);
      n++;
    end
    chk("boot finish", 8'h01, 8'(n < 800)); // boot settles
  endtask

  task automatic t_fabric_first();
    for (int k = 0; k < 3; k++)
    begin
      reset_dut(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, bcs_src_e'(k)));
      wait_end();
      chk_q("fabric-first order", ff_q, codes_q); // order
      chk("processor reset", 8'h01, prst_n); // release
      chk("fabric done", 8'h01, fab); // whole fabric
      chk("pin release", 8'h01, pin_oe_n); // pin follows
      chk("source", 8'(k), 8'(src)); // every source
      chk_q("image", '{3'h0}, imgs_q); // factory image only
    end
  endtask

  task automatic t_proc_first();
    reset_dut(mk(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, SRC_FLASH));
    wait_end();
    chk_q("processor-first order", pf_q, codes_q); // order
    chk("processor reset", 8'h01, prst_n); // release
    chk("fabric done", 8'h00, fab); // fabric left
    chk("memory io done", 8'h01, mio); // memory port
  endtask

  task automatic t_fabric_err();
    fcode = STEP_CFG_FABRIC;
    fmask = 8'h01;
    reset_dut(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SRC_FLASH));
    wait_end();
    repeat (20) @(negedge clk);
    chk("boot fail", 8'h01, bfail); // error seen
    chk("processor reset", 8'h00, prst_n); // held
    chk("pin drive", 8'h00, pin_oe_n); // held too
    chk("steps", 8'h04, 8'(codes_q.size())); // stops at error
    fmask = 8'h00;
  endtask

  task automatic t_update();
    order = {3'h2, 3'h1, 3'h3, 3'h5};
    fcode = STEP_VERIFY_BS;
    fmask = 8'h2E;
    dly = 4'h3;
    reset_dut(mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, SRC_FLASH));
    wait_end();
    chk_q("image order", '{3'h5, 3'h3, 3'h1, 3'h2, 3'h0}, imgs_q);
    chk("factory", 8'h01, fsel); // fallback
    chk("rejected then boot", 8'h01, prst_n);
    reset_dut(mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, SRC_FLASH));
    wait_end();
    chk_q("direct factory", '{3'h0}, imgs_q); // skip production
    fmask = 8'h00;
    dly = 4'h0;
  endtask

  task automatic t_cfg_req();
    cfg_n = 1'b0;
    reset_dut(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SRC_FLASH));
    repeat (10) @(negedge clk);
    chk("held steps", 8'h00, 8'(codes_q.size())); // postponed
    cfg_n = 1'b1;
    wait_end();
    cfg_n = 1'b0;
    @(negedge clk);
    chk("processor reset", 8'h00, prst_n); // cold reset
    chk("pin drive", 8'h00, pin_oe_n); // pin follows
    chk("fabric done", 8'h00, fab); // reconfiguration
    codes_q.delete();
    repeat (5) @(negedge clk);
    chk("held steps", 8'h00, 8'(codes_q.size())); // held
    cfg_n = 1'b1;
    wait_end();
    chk_q("reconfig order", ff_q, codes_q); // full reconfig
  endtask

  task automatic t_cold_pin();
    codes_q.delete();
    ext_low = 1'b1;
    @(negedge clk);
    ext_low = 1'b0;
    chk("processor reset", 8'h00, prst_n); // cold reset
    chk("fabric kept", 8'h01, fab); // fabric untouched
    chk("pin level", 8'h00, 8'(pin)); // drives board reset
    wait_end();
    chk_q("reload", '{STEP_LOAD_LOADER}, codes_q); // loader only
    chk("pin level", 8'h01, 8'(pin)); // released
  endtask

  task automatic t_security();
    for (int i = 0; i < 4; i++)
    begin
      owner = i[0];
      sreq = i[1];
      repeat (2) @(negedge clk);
      chk("security enable", 8'(i == 3), sen);
      chk("security refused", 8'(i == 2), sref);
    end
    for (int f = 0; f < 2; f++)
    begin
      kfuse = f[0];
      kwipe = 1'b1;
      @(negedge clk);
      kwipe = 1'b0;
      chk("key wipe", 8'(f == 0), kwo); // battery key only
      chk("key permanent", 8'(f), kperm); // fuse key
    end
  endtask

  task automatic t_fuses();
    for (int c = 0; c < 2; c++)
    begin
      hash_ok = c[0];
      key_cnc = c[0];
      reset_dut(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SRC_FLASH));
      wait_end();
      chk("boot fail", 8'h01, bfail); // fuse check
      chk_q("auth only", '{STEP_AUTH_FW}, codes_q); // auth first
    end
    hash_ok = 1'b1;
    key_cnc = 1'b0;
  endtask

  task automatic t_eng();
    for (int c = 0; c < 3; c++)
    begin
      reset_dut(mk(c > 0, 1'b1, c != 1, 1'b0, 1'b0, SRC_FLASH));
      wait_end();
      chk("sample boot", 8'(c == 2), prst_n);
      chk("sample fail", 8'(c != 2), bfail);
    end
  endtask

  initial
  begin
    rst_b = 1'b0;
    cfg_n = 1'b1;
    ext_low = 1'b0;
    hash_ok = 1'b1;
    key_cnc = 1'b0;
    owner = 1'b0;
    sreq = 1'b0;
    kfuse = 1'b0;
    kwipe = 1'b0;
    fmask = 8'h00;
    fcode = STEP_AUTH_FW;
    dly = 4'h0;
    order = {3'h4, 3'h3, 3'h2, 3'h1};
    straps = mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SRC_FLASH);
    @(negedge clk);
    reset_dut(straps);
    chk("reset hold", 8'h00, prst_n); // held from power-on
    chk("reset factory", 8'h01, fsel); // factory at reset
    t_fabric_first();
    t_cold_pin();
    t_proc_first();
    t_fabric_err();
    t_update();
    t_cfg_req();
    t_security();
    t_fuses();
    t_eng();
    end_of_test();
  end
endmodule
